// *** verilog/card_params.svh ***
`ifndef CARD_PARAMS_SVH
`define CARD_PARAMS_SVH
`define CFG_OPT0_IDX 4'h0
`define CFG_OPT1_IDX 4'h1
`define STATUS0_IDX 4'h2
`define STATUS1_IDX 4'h3
`define BASE0_IDX 4'h4
`define LIMIT0_IDX 4'h5
`define BASE1_IDX 4'h6
`define LIMIT1_IDX 4'h7
`define POLARITY_IDX 4'h8
`define IDENT_IDX 4'h9
`define EE_CTRL_IDX 4'ha
`define CIS_DEPTH 16
`define SHADOW_DEFAULTS 9
`define CFG_OPT_RESET 16'h0000
`define IDENT_RESET 16'h00a5
`define PULSE_CYCLES 16
`define OPT_LEVEL_BIT 6
`define STAT_INTR_BIT 1
`define STAT_PROTO_BIT 0
`define POL_BYTE_WIDE_BIT 0
`define EE_SAVE_BIT 0
`endif

// *** verilog/card_pkg.sv ***
package card_pkg;
  typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_SAVE} mode_e;
  typedef logic [15:0] word_t;
endpackage

// *** verilog/card_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface card_link_if;
  logic io_rd;
  logic io_wr;
  logic attr_rd;
  logic attr_wr;
  logic mem_wr;
  logic is16;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic host_reset;
  logic irq_n;
  modport device(input io_rd, io_wr, attr_rd, attr_wr, mem_wr, is16, addr, wdata, host_reset,
    output rdata, irq_n);
  modport host(output io_rd, io_wr, attr_rd, attr_wr, mem_wr, is16, addr, wdata, host_reset,
    input rdata, irq_n);
endinterface
`default_nettype wire

// *** verilog/irq_pulser.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "card_params.svh"
module irq_pulser
#(
  parameter int PULSE_LEN = `PULSE_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fire_i,
  input wire logic level_mode_i,
  input wire logic level_i,
  output logic irq_o
);
  logic [$clog2(PULSE_LEN+1)-1:0] count;
  // A pulse is fired on the rising edge of the request and lasts PULSE_LEN cycles.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count <= '0;
    else if (fire_i && count == '0)
      count <= ($clog2(PULSE_LEN+1))'(PULSE_LEN);
    else if (count != '0)
      count <= count - 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= level_mode_i ? level_i : (fire_i || count > 1);
  end
endmodule
`default_nettype wire

// *** verilog/card_device.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "card_params.svh"
// Contract
// - Matching I/O access routes to its function.
// - Each function has base and limit.
// - Pin reset first reloads CIS from EEPROM.
// - Pin reset clears both configuration options.
// - Pin reset restores all other defaults.
// - Power-on copies EEPROM into shadow RAM.
// - Written defaults can be saved to EEPROM.
// - Non-backed registers read/write via attribute space.
// - Either function request raises host interrupt.
// - Pulsed mode pulse lasts sixteen clocks.
// - Host should prefer level mode for dual.
// - Status shows source; held until serviced, but in OR mode the pending bit clears once the request drops.
// - Protocol bit selects OR or enhanced.
// - Software should set protocol bits for dual.
// - Software clears pending bit after service.
// - Enhanced: no new interrupt until cleared.
// - Default sixteen bit; byte passed unchanged.
// - Word memory: byte uses low/high by address.
// - Word memory: word access strobes both.
// - Byte memory: byte accesses use low only.
// - Byte memory: word access low strobe only.
// - Function 0 alone works as single function.
module card_device
  import card_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  card_link_if.device link,
  input wire logic [1:0] function_interrupt_request_i,
  output logic [1:0] func_sel_o,
  output logic func_rd_o,
  output logic func_wr_o,
  output logic [15:0] func_addr_o,
  output logic [15:0] func_wdata_o,
  input wire logic [15:0] func_rdata_i,
  output logic memory_write_strobe_low_n_o,
  output logic memory_write_strobe_high_n_o,
  output logic ee_rd_o,
  output logic ee_wr_o,
  output logic [3:0] ee_addr_o,
  output logic [15:0] ee_wdata_o,
  input wire logic [15:0] ee_rdata_i,
  output logic busy_o
);
  localparam int DEPTH = `CIS_DEPTH;
  mode_e mode;
  logic [3:0] ptr;
  word_t shadow [DEPTH];
  word_t cfg_opt [2];
  word_t status [2];
  word_t base [2];
  word_t limit [2];
  word_t polarity;
  word_t ident;
  word_t ee_ctrl;
  logic [1:0] req_s1, req_s2, req_q, pending;
  logic fire, level_req;
  logic irq;
  logic [15:0] addr;

  function automatic logic hit(input word_t a, input word_t b, input word_t l);
    hit = (a >= b) && (a <= b + l);
  endfunction

  assign addr = link.addr;

  // EEPROM load at reset and save on request.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || link.host_reset)
    begin
      mode <= ST_LOAD;
      ptr <= '0;
    end
    else
      case (mode)
        ST_LOAD:
        begin
          if (ptr == 4'(DEPTH - 1))
            mode <= ST_RUN;
          ptr <= ptr + 1'b1;
        end
        ST_RUN:
        begin
          if (link.attr_wr && addr[3:0] == `EE_CTRL_IDX && link.wdata[`EE_SAVE_BIT])
          begin
            mode <= ST_SAVE;
            ptr <= '0;
          end
        end
        ST_SAVE:
        begin
          if (ptr == 4'(DEPTH - 1))
            mode <= ST_RUN;
          ptr <= ptr + 1'b1;
        end
        default: mode <= ST_RUN;
      endcase
  end

  // Read data belongs to the registered address, so each word lands one cycle after its request.
  always_ff @(posedge clk_i)
  begin
    if (ee_rd_o)
      shadow[ee_addr_o] <= ee_rdata_i;
    else if (mode == ST_RUN && link.attr_wr && addr[8])
      shadow[addr[3:0]] <= link.wdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || link.host_reset)
    begin
      ee_rd_o <= 1'b0;
      ee_wr_o <= 1'b0;
      ee_addr_o <= '0;
      ee_wdata_o <= '0;
      busy_o <= 1'b1;
    end
    else
    begin
      ee_rd_o <= (mode == ST_LOAD);
      ee_wr_o <= (mode == ST_SAVE);
      ee_addr_o <= ptr;
      ee_wdata_o <= shadow[ptr];
      busy_o <= (mode != ST_RUN);
    end
  end

  // Configuration registers; shadow words supply defaults after load.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || link.host_reset)
    begin
      cfg_opt[0] <= `CFG_OPT_RESET;
      cfg_opt[1] <= `CFG_OPT_RESET;
      base[0] <= '0;
      base[1] <= '0;
      limit[0] <= '0;
      limit[1] <= '0;
      polarity <= '0;
      ident <= `IDENT_RESET;
      ee_ctrl <= '0;
    end
    else if (mode == ST_LOAD && ptr == 4'(DEPTH - 1))
    begin
      base[0] <= shadow[0];
      limit[0] <= shadow[1];
      base[1] <= shadow[2];
      limit[1] <= shadow[3];
      polarity <= shadow[4];
    end
    else if (mode == ST_RUN && link.attr_wr && !addr[8])
      case (addr[3:0])
        `CFG_OPT0_IDX: cfg_opt[0] <= link.wdata;
        `CFG_OPT1_IDX: cfg_opt[1] <= link.wdata;
        `BASE0_IDX: base[0] <= link.wdata;
        `LIMIT0_IDX: limit[0] <= link.wdata;
        `BASE1_IDX: base[1] <= link.wdata;
        `LIMIT1_IDX: limit[1] <= link.wdata;
        `POLARITY_IDX: polarity <= link.wdata;
        `IDENT_IDX: ident <= link.wdata;
        `EE_CTRL_IDX: ee_ctrl <= link.wdata;
        default: ;
      endcase
  end

  // Interrupt requests arrive from other logic domains, so they are synchronised.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_s1 <= '0;
      req_s2 <= '0;
      req_q <= '0;
    end
    else
    begin
      req_s1 <= function_interrupt_request_i;
      req_s2 <= req_s1;
      req_q <= req_s2;
    end
  end

  genvar f;
  generate
    for (f = 0; f < 2; f++)
    begin : g_fn
      always_ff @(posedge clk_i)
      begin
        if (rst_i || link.host_reset)
          status[f] <= '0;
        else
        begin
          if (link.attr_wr && mode == ST_RUN && !addr[8]
              && addr[3:0] == (f == 0 ? `STATUS0_IDX : `STATUS1_IDX))
            status[f][`STAT_PROTO_BIT] <= link.wdata[`STAT_PROTO_BIT];
          // A new request wins over a clear in the same cycle.
          // In enhanced mode a request still held after the clear raises the next interrupt.
          if ((req_s2[f] && !req_q[f])
              || (status[f][`STAT_PROTO_BIT] && req_s2[f] && !status[f][`STAT_INTR_BIT]))
            status[f][`STAT_INTR_BIT] <= 1'b1;
          else if (link.attr_wr && mode == ST_RUN && !addr[8]
              && addr[3:0] == (f == 0 ? `STATUS0_IDX : `STATUS1_IDX)
              && !link.wdata[`STAT_INTR_BIT])
            status[f][`STAT_INTR_BIT] <= 1'b0;
          else if (!status[f][`STAT_PROTO_BIT] && !req_s2[f])
            status[f][`STAT_INTR_BIT] <= 1'b0;
        end
      end
      assign pending[f] = status[f][`STAT_INTR_BIT];
    end
  endgenerate

  // Enhanced mode holds off a new edge while any pending bit stands.
  logic enhanced, blocked, level_d;
  assign enhanced = status[0][`STAT_PROTO_BIT] | status[1][`STAT_PROTO_BIT];
  assign level_req = enhanced ? |pending : |req_s2;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      level_d <= 1'b0;
      blocked <= 1'b0;
    end
    else
    begin
      level_d <= level_req;
      blocked <= enhanced && |pending;
    end
  end
  assign fire = level_req && (!level_d || (enhanced && !blocked && |pending && !level_d));

  // A pin reset also cuts a running pulse, so the host never sees a stale request.
  irq_pulser u_pulse (
    .clk_i(clk_i),
    .rst_i(rst_i || link.host_reset),
    .fire_i(fire),
    .level_mode_i(cfg_opt[0][`OPT_LEVEL_BIT]),
    .level_i(level_req),
    .irq_o(irq)
  );
  assign link.irq_n = ~irq;

  // I/O window decode and memory write strobes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      func_sel_o <= '0;
      func_rd_o <= 1'b0;
      func_wr_o <= 1'b0;
      func_addr_o <= '0;
      func_wdata_o <= '0;
      memory_write_strobe_low_n_o <= 1'b1;
      memory_write_strobe_high_n_o <= 1'b1;
    end
    else
    begin
      func_sel_o[0] <= hit(addr, base[0], limit[0]);
      func_sel_o[1] <= hit(addr, base[1], limit[1]) && !hit(addr, base[0], limit[0]);
      func_rd_o <= link.io_rd && (hit(addr, base[0], limit[0]) || hit(addr, base[1], limit[1]));
      func_wr_o <= link.io_wr && (hit(addr, base[0], limit[0]) || hit(addr, base[1], limit[1]));
      func_addr_o <= addr;
      func_wdata_o <= link.wdata;
      if (polarity[`POL_BYTE_WIDE_BIT])
      begin
        memory_write_strobe_low_n_o <= !link.mem_wr;
        memory_write_strobe_high_n_o <= 1'b1;
      end
      else
      begin
        memory_write_strobe_low_n_o <= !(link.mem_wr && (link.is16 || !addr[0]));
        memory_write_strobe_high_n_o <= !(link.mem_wr && (link.is16 || addr[0]));
      end
    end
  end

  always_comb
  begin
    if (link.io_rd)
      link.rdata = func_rdata_i;
    else if (addr[8])
      link.rdata = shadow[addr[3:0]];
    else
      case (addr[3:0])
        `CFG_OPT0_IDX: link.rdata = cfg_opt[0];
        `CFG_OPT1_IDX: link.rdata = cfg_opt[1];
        `STATUS0_IDX: link.rdata = status[0];
        `STATUS1_IDX: link.rdata = status[1];
        `BASE0_IDX: link.rdata = base[0];
        `LIMIT0_IDX: link.rdata = limit[0];
        `BASE1_IDX: link.rdata = base[1];
        `LIMIT1_IDX: link.rdata = limit[1];
        `POLARITY_IDX: link.rdata = polarity;
        `IDENT_IDX: link.rdata = ident;
        `EE_CTRL_IDX: link.rdata = {ee_ctrl[15:1], busy_o};
        default: link.rdata = '0;
      endcase
  end
endmodule
`default_nettype wire

// *** verilog/card_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "card_params.svh"
module card_host
  import card_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  card_link_if.host link,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic attr_rd_i,
  input wire logic attr_wr_i,
  input wire logic mem_wr_i,
  input wire logic is16_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic card_reset_i,
  output logic [15:0] rdata_o,
  output logic irq_o
);
  logic irq_s1, irq_s2;
  // Requests are registered so that the card sees one stable cycle each.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      link.io_rd <= 1'b0;
      link.io_wr <= 1'b0;
      link.attr_rd <= 1'b0;
      link.attr_wr <= 1'b0;
      link.mem_wr <= 1'b0;
      link.is16 <= 1'b1;
      link.addr <= '0;
      link.wdata <= '0;
      link.host_reset <= 1'b1;
    end
    else
    begin
      link.io_rd <= io_rd_i;
      link.io_wr <= io_wr_i;
      link.attr_rd <= attr_rd_i;
      link.attr_wr <= attr_wr_i;
      link.mem_wr <= mem_wr_i;
      link.is16 <= is16_i;
      link.addr <= addr_i;
      link.wdata <= wdata_i;
      link.host_reset <= card_reset_i;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= '0;
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      rdata_o <= link.rdata;
      irq_s1 <= ~link.irq_n;
      irq_s2 <= irq_s1;
      irq_o <= irq_s2;
    end
  end
endmodule
`default_nettype wire

// *** dv/card_link_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "card_params.svh"
module card_link_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic attr_rd,
  input wire logic attr_wr,
  input wire logic mem_wr,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic host_reset,
  input wire logic irq_n
);
  logic level;
  logic [7:0] low_cnt;
  // The mode is tracked from the host's writes, so writes taken while busy must not occur.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || host_reset)
      level <= 1'b0;
    else if (attr_wr && !addr[8] && addr[3:0] == `CFG_OPT0_IDX)
      level <= wdata[`OPT_LEVEL_BIT];
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || irq_n)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hff)
      low_cnt <= low_cnt + 8'h01;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_pulse_exact_len: assert property (!level && $rose(irq_n) && !$past(host_reset) |->
    low_cnt == 8'h10) else $error("pulse length wrong");
  chk_pulse_max_len: assert property (!level && !irq_n |-> low_cnt < 8'h10)
    else $error("pulse too long");
  chk_pin_reset_quiet: assert property (host_reset [*2] |-> irq_n)
    else $error("interrupt during pin reset");
  chk_one_access: assert property ($onehot0({io_rd, io_wr, attr_rd, attr_wr, mem_wr}))
    else $error("two accesses at once");
  chk_reset_cuts_irq: assert property (host_reset |=> irq_n)
    else $error("interrupt survived pin reset");
  chk_reset_end_quiet: assert property ($fell(host_reset) |-> irq_n)
    else $error("interrupt at end of pin reset");
  cover property (!level && $rose(irq_n));
endmodule
`default_nettype wire

// *** dv/dual_function_card_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "card_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dual_function_card_control_tb;
  import card_pkg::*;
  localparam logic [4:0] IOR = 5'h10;
  localparam logic [4:0] IOW = 5'h08;
  localparam logic [4:0] ATR = 5'h04;
  localparam logic [4:0] ATW = 5'h02;
  localparam logic [4:0] MW = 5'h01;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] stb = 5'h00;
  logic is16 = 1'b1;
  logic card_rst = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] frd = 16'h0000;
  logic [1:0] req = 2'h0;
  logic [15:0] ee [16];
  word_t rdata, faddr, fwd, ee_wd;
  logic [1:0] fsel;
  logic irq, frs, fwr, wel_n, weh_n, ee_rd, ee_wr, busy;
  logic [3:0] ee_a;
  logic [15:0] a, d;
  int failures = 0;
  int total_checks = 0;
  int k, n;
  card_link_if link();
  card_host i_card_host (.clk_i(clk_i), .rst_i(rst_i), .link(link), .io_rd_i(stb[4]),
    .io_wr_i(stb[3]), .attr_rd_i(stb[2]), .attr_wr_i(stb[1]), .mem_wr_i(stb[0]), .is16_i(is16),
    .addr_i(addr), .wdata_i(wdata), .card_reset_i(card_rst), .rdata_o(rdata), .irq_o(irq));
  card_device i_card_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .function_interrupt_request_i(req), .func_sel_o(fsel), .func_rd_o(frs), .func_wr_o(fwr),
    .func_addr_o(faddr), .func_wdata_o(fwd), .func_rdata_i(frd),
    .memory_write_strobe_low_n_o(wel_n), .memory_write_strobe_high_n_o(weh_n), .ee_rd_o(ee_rd),
    .ee_wr_o(ee_wr), .ee_addr_o(ee_a), .ee_wdata_o(ee_wd), .ee_rdata_i(ee[ee_a]), .busy_o(busy));
  card_link_monitor i_card_link_monitor (.clk_i(clk_i), .rst_i(rst_i), .io_rd(link.io_rd),
    .io_wr(link.io_wr), .attr_rd(link.attr_rd), .attr_wr(link.attr_wr), .mem_wr(link.mem_wr),
    .addr(link.addr), .wdata(link.wdata), .host_reset(link.host_reset), .irq_n(link.irq_n));
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (ee_wr === 1'b1)
      ee[ee_a] <= ee_wd;
  end
  task summarize;
  begin
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // One host cycle, then one more so the registered answer has landed.
  task acc(input logic [4:0] s, input logic w16, input logic [15:0] ad, input logic [15:0] dt);
  begin
    stb = s;
    is16 = w16;
    addr = ad;
    wdata = dt;
    @(negedge clk_i);
    stb = 5'h00;
    @(negedge clk_i);
  end
  endtask
  task wr(input logic [15:0] ad, input logic [15:0] dt);
  begin
    acc(ATW, 1'b1, ad, dt);
  end
  endtask
  task rd(input logic [15:0] ad, input logic [15:0] e);
  begin
    acc(ATR, 1'b1, ad, 16'h0000);
    `CHK(rdata, e)
  end
  endtask
  task wbusy;
    int i;
  begin
    for (i = 0; i < 300 && busy !== 1'b0; i++)
      @(negedge clk_i);
    if (busy !== 1'b0)
    begin
      failures++;
      summarize();
    end
  end
  endtask
  task wirq(output int cnt);
    int i;
  begin
    cnt = 0;
    for (i = 0; i < 60 && irq !== 1'b1; i++)
      @(negedge clk_i);
    while (irq === 1'b1 && cnt < 60)
    begin
      cnt++;
      @(negedge clk_i);
    end
  end
  endtask
  initial
  begin
    void'($urandom(32'h62006fe7));
    for (k = 0; k < 16; k++)
      ee[k] = 16'($urandom);
    ee[0] = 16'h0100;
    ee[1] = 16'h0007;
    ee[2] = 16'h0200;
    ee[3] = 16'h000f;
    ee[4] = 16'h0000;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    wbusy();
    rd(16'h0000, `CFG_OPT_RESET);
    rd(16'h0009, `IDENT_RESET);
    rd(16'h0004, 16'h0100);
    rd(16'h0103, 16'h000f);
    d = 16'($urandom);
    wr(16'h0009, d);
    rd(16'h0009, d);
    $display("test defaults done");
    for (k = 0; k < 6; k++)
    begin
      a = (k[0] ? 16'h0200 : 16'h0100) + 16'($urandom % 8);
      d = 16'($urandom);
      acc(IOW, k[1], a, d);
      `CHK(fsel, (k[0] ? 2'h2 : 2'h1))
      `CHK(fwr, 1'b1)
      `CHK(faddr, a)
      `CHK(fwd, d)
    end
    acc(IOW, 1'b1, 16'h0300, d);
    `CHK(fwr, 1'b0)
    frd = 16'($urandom);
    acc(IOR, 1'b0, 16'h0101, 16'h0000);
    `CHK(rdata, frd)
    $display("test windows done");
    for (k = 0; k < 8; k++)
    begin
      wr(16'h0008, {15'h0000, k[2]});
      acc(MW, k[1], 16'h0040 | 16'(k[0]), 16'($urandom));
      `CHK(wel_n, !(k[2] | k[1] | !k[0]))
      `CHK(weh_n, !(!k[2] & (k[1] | k[0])))
    end
    $display("test strobes done");
    req = 2'h1;
    wirq(n);
    `CHK(n, `PULSE_CYCLES)
    acc(ATR, 1'b1, 16'h0002, 16'h0000);
    `CHK(rdata[`STAT_INTR_BIT], 1'b1)
    req = 2'h0;
    wr(16'h0002, 16'h0000);
    wr(16'h0003, 16'h0001);
    req = 2'h2;
    wirq(n);
    `CHK(n, `PULSE_CYCLES)
    req = 2'h0;
    repeat (4) @(negedge clk_i);
    req = 2'h2;
    wirq(n);
    `CHK(n, 0)
    wr(16'h0003, 16'h0001);
    wirq(n);
    `CHK(n, `PULSE_CYCLES)
    req = 2'h0;
    $display("test interrupts done");
    d = 16'($urandom);
    wr(16'h0105, d);
    wr(16'h000a, 16'h0001);
    repeat (2) @(negedge clk_i);
    wbusy();
    `CHK(ee[5], d)
    wr(16'h0000, 16'h0040);
    card_rst = 1'b1;
    repeat (2) @(negedge clk_i);
    card_rst = 1'b0;
    repeat (3) @(negedge clk_i);
    wbusy();
    rd(16'h0000, `CFG_OPT_RESET);
    rd(16'h0105, d);
    rd(16'h0009, `IDENT_RESET);
    $display("test save and reset done");
    summarize();
  end
endmodule
`default_nettype wire
